// ===== design/psab_defines.svh
`ifndef PSAB_DEFINES_SVH
`define PSAB_DEFINES_SVH
// attribute identifiers
`define PSAB_ID_CRC_ERR      16'h00a0
`define PSAB_ID_BAD_PROTO    16'h00a1
`define PSAB_ID_TX_DROP      16'h00a2
`define PSAB_ID_RX_DROP      16'h00a3
`define PSAB_ID_GOOD_FRAME   16'h00a4
`define PSAB_ID_EVM_AVG      16'h00a5
`define PSAB_ID_EMA_SHIFT    16'h00a8
// first identifier of the vendor range
`define PSAB_ID_VENDOR_BASE  16'h8000
// reset values
`define PSAB_RST_CNT16       16'h0000
`define PSAB_RST_CNT32       32'h0000_0000
`define PSAB_RST_EMA_SHIFT   8'h00
// frames per evm block
`define PSAB_EVM_BLOCK_LEN   5'h10
`endif

// ===== design/psab_pkg.sv
package psab_pkg;
  typedef logic [15:0] psab_id_t;
  typedef logic [31:0] psab_data_t;
  typedef enum logic [1:0] {
    PSAB_ANS_OK       = 2'h0,
    PSAB_ANS_RESERVED = 2'h1,
    PSAB_ANS_VENDOR   = 2'h2
  } psab_status_e;
endpackage

// ===== design/psab_evm_if.sv
`timescale 1ns/100ps
interface psab_evm_if;
  logic        snr_valid;  // one snr report
  logic [2:0]  snr_db;     // report in db steps
  logic [15:0] block_sum;  // last completed block sum
  modport owner (output snr_valid, output snr_db, input block_sum);
  modport acc   (input snr_valid, input snr_db, output block_sum);
endinterface // psab_evm_if

// ===== design/psab_evm_acc.sv
`timescale 1ns/100ps
`include "psab_defines.svh"
module psab_evm_acc (
  input wire logic CLK,       // clock
  input wire logic ARST_N,    // async reset
  psab_evm_if.acc  evm        // snr in, block sum out
);
  import psab_pkg::*;
  logic [15:0] sum_reg,   sum_next;
  logic [15:0] block_reg, block_next;
  logic [4:0]  cnt_reg,   cnt_next;

  // 2^(k/2) in 4.3 fixed point, rounded
  function automatic logic [6:0] db_to_lin(input logic [2:0] k);
    case (k)
      3'h0:    db_to_lin = 7'h08;
      3'h1:    db_to_lin = 7'h0b;
      3'h2:    db_to_lin = 7'h10;
      3'h3:    db_to_lin = 7'h17;
      3'h4:    db_to_lin = 7'h20;
      3'h5:    db_to_lin = 7'h2d;
      3'h6:    db_to_lin = 7'h40;
      default: db_to_lin = 7'h5b;
    endcase
  endfunction

  // accumulate 16 frames, then publish; max 16*91 fits in 16 bits
  always_comb begin
    sum_next   = sum_reg;
    block_next = block_reg;
    cnt_next   = cnt_reg;
    if (evm.snr_valid) begin
      if (cnt_reg == `PSAB_EVM_BLOCK_LEN - 5'h01) begin
        block_next = sum_reg + {9'h000, db_to_lin(evm.snr_db)}; // [R11]
        sum_next   = `PSAB_RST_CNT16;
        cnt_next   = 5'h00;
      end else begin
        sum_next = sum_reg + {9'h000, db_to_lin(evm.snr_db)}; // [R11]
        cnt_next = cnt_reg + 5'h01;
      end
    end
  end

  // cleared at reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sum_reg   <= `PSAB_RST_CNT16; // [R13]
      block_reg <= `PSAB_RST_CNT16; // [R13]
      cnt_reg   <= 5'h00;
    end else begin
      sum_reg   <= sum_next;
      block_reg <= block_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign evm.block_sum = block_reg;
endmodule // psab_evm_acc

// ===== design/psab_stats_bank.sv
// What this block does
// R01: attributes selected by 16-bit identifier
// R02: vendor range 0x8000 up, none defined
// R03: undefined standard identifiers answer reserved
// R04: registers at least the specified width
// R05: statistics returned on management get request
// R06: count bursts failing crc
// R07: count crc-good bursts with bad protocol; counts PROTO_BAD even when CRC_FAIL is set
// R08: count transmit requests hitting full queue
// R09: count received data hitting full queue
// R10: 32-bit count of correctly decoded frames
// R11: snr to linear, summed over 16 frames
// R12: ema shift value, moving average update
// R13: counters clear on reset, wrap at max
`timescale 1ns/100ps
`include "psab_defines.svh"
module psab_stats_bank (
  input  wire logic              CLK,             // 25 MHz clock
  input  wire logic              ARST_N,          // async reset, active low
  input  wire logic              GET_REQ,         // get request strobe
  input  wire psab_pkg::psab_id_t GET_ID,         // attribute identifier
  output logic                   GET_CNF,         // answer strobe
  output psab_pkg::psab_data_t   GET_DATA,        // attribute value, low aligned
  output psab_pkg::psab_status_e GET_STATUS,      // answer status
  input  wire logic              CRC_FAIL,        // burst with bad crc
  input  wire logic              PROTO_BAD,       // crc ok, bad protocol field
  input  wire logic              TX_REQ,          // new transmit request
  input  wire logic              TX_FULL,         // transmit queue full
  input  wire logic              RX_NEW,          // new channel data
  input  wire logic              RX_FULL,         // receive queue full
  input  wire logic              FRAME_OK,        // frame decoded correctly
  input  wire logic              SNR_VALID,       // snr report strobe
  input  wire logic [2:0]        SNR_DB,          // snr report in db
  input  wire logic              EMA_LOAD,        // load smoothing setting
  input  wire logic [7:0]        EMA_VALUE,       // smoothing setting value
  input  wire logic              EMA_SAMPLE_VALID,// new ema sample
  input  wire logic [15:0]       EMA_SAMPLE,      // sample to be smoothed
  output logic [15:0]            EMA_AVG          // smoothed value
);
  import psab_pkg::*;

  typedef enum logic [1:0] {
    PSAB_ST_IDLE   = 2'b01,
    PSAB_ST_ANSWER = 2'b10
  } psab_state_e;

  psab_state_e state_reg, state_next;
  logic [15:0] crc_error_burst_count_reg,    crc_error_burst_count_next;
  logic [15:0] bad_protocol_burst_count_reg, bad_protocol_burst_count_next;
  logic [15:0] tx_overflow_drop_count_reg,   tx_overflow_drop_count_next;
  logic [15:0] rx_overflow_drop_count_reg,   rx_overflow_drop_count_next;
  logic [31:0] good_frame_total_count_reg,   good_frame_total_count_next;
  logic [7:0]  moving_average_shift_reg,     moving_average_shift_next;
  logic [15:0] ema_reg,                      ema_next;
  logic        cnf_reg,                      cnf_next;
  psab_data_t  data_reg,                     data_next;
  psab_status_e status_reg,                  status_next;
  logic [15:0] evm_block_average;

  psab_evm_if evm ();

  assign evm.snr_valid = SNR_VALID;
  assign evm.snr_db    = SNR_DB;
  assign evm_block_average = evm.block_sum;

  // block averaging of snr reports kept apart for reuse
  psab_evm_acc u_evm (
    .CLK    (CLK),
    .ARST_N (ARST_N),
    .evm    (evm)
  );

  // counters wrap naturally by modular add
  function automatic logic [15:0] inc16(input logic [15:0] v, input logic en);
    inc16 = en ? v + 16'h0001 : v; // [R13]
  endfunction

  // event counters
  always_comb begin
    crc_error_burst_count_next    = inc16(crc_error_burst_count_reg, CRC_FAIL); // [R06]
    bad_protocol_burst_count_next = inc16(bad_protocol_burst_count_reg, PROTO_BAD); // [R07]
    tx_overflow_drop_count_next   = inc16(tx_overflow_drop_count_reg,
                                          TX_REQ & TX_FULL); // [R08]
    rx_overflow_drop_count_next   = inc16(rx_overflow_drop_count_reg,
                                          RX_NEW & RX_FULL); // [R09]
    good_frame_total_count_next   = FRAME_OK ? good_frame_total_count_reg + 32'h0000_0001
                                             : good_frame_total_count_reg; // [R10]
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      crc_error_burst_count_reg    <= `PSAB_RST_CNT16; // [R13]
      bad_protocol_burst_count_reg <= `PSAB_RST_CNT16;
      tx_overflow_drop_count_reg   <= `PSAB_RST_CNT16;
      rx_overflow_drop_count_reg   <= `PSAB_RST_CNT16;
      good_frame_total_count_reg   <= `PSAB_RST_CNT32;
    end else begin
      crc_error_burst_count_reg    <= crc_error_burst_count_next;
      bad_protocol_burst_count_reg <= bad_protocol_burst_count_next;
      tx_overflow_drop_count_reg   <= tx_overflow_drop_count_next;
      rx_overflow_drop_count_reg   <= rx_overflow_drop_count_next;
      good_frame_total_count_reg   <= good_frame_total_count_next;
    end
  end

  // smoothing: next = prev + (sample - prev) >> shift; shift past 16 holds prev
  always_comb begin
    logic signed [17:0] diff;
    diff = 18'sh00000;
    moving_average_shift_next = EMA_LOAD ? EMA_VALUE : moving_average_shift_reg; // [R12]
    ema_next = ema_reg;
    if (EMA_SAMPLE_VALID) begin
      diff = $signed({2'b00, EMA_SAMPLE}) - $signed({2'b00, ema_reg});
      if (moving_average_shift_reg < 8'h11) begin
        ema_next = 16'(ema_reg + 16'(diff >>> moving_average_shift_reg)); // [R12]
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      moving_average_shift_reg <= `PSAB_RST_EMA_SHIFT;
      ema_reg                  <= `PSAB_RST_CNT16;
    end else begin
      moving_average_shift_reg <= moving_average_shift_next;
      ema_reg                  <= ema_next;
    end
  end

  // get request decode; one-cycle answer, values zero-extended to 32 bits
  always_comb begin
    state_next  = state_reg;
    cnf_next    = 1'b0;
    data_next   = data_reg;
    status_next = status_reg;
    case (state_reg)
      PSAB_ST_IDLE: begin
        if (GET_REQ) begin // [R05]
          state_next  = PSAB_ST_ANSWER;
          cnf_next    = 1'b1;
          status_next = PSAB_ANS_OK;
          case (GET_ID) // [R01]
            `PSAB_ID_CRC_ERR:    data_next = {16'h0000, crc_error_burst_count_reg}; // [R04]
            `PSAB_ID_BAD_PROTO:  data_next = {16'h0000, bad_protocol_burst_count_reg};
            `PSAB_ID_TX_DROP:    data_next = {16'h0000, tx_overflow_drop_count_reg};
            `PSAB_ID_RX_DROP:    data_next = {16'h0000, rx_overflow_drop_count_reg};
            `PSAB_ID_GOOD_FRAME: data_next = good_frame_total_count_reg;
            `PSAB_ID_EVM_AVG:    data_next = {16'h0000, evm_block_average};
            `PSAB_ID_EMA_SHIFT:  data_next = {24'h000000, moving_average_shift_reg};
            default: begin
              data_next   = 32'h0000_0000;
              // no vendor attributes are defined here
              status_next = (GET_ID >= `PSAB_ID_VENDOR_BASE) ? PSAB_ANS_VENDOR // [R02]
                                                             : PSAB_ANS_RESERVED; // [R03]
            end
          endcase
        end
      end
      PSAB_ST_ANSWER: state_next = PSAB_ST_IDLE; // one idle cycle between answers
      default:        state_next = PSAB_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg  <= PSAB_ST_IDLE;
      cnf_reg    <= 1'b0;
      data_reg   <= `PSAB_RST_CNT32;
      status_reg <= PSAB_ANS_OK;
    end else begin
      state_reg  <= state_next;
      cnf_reg    <= cnf_next;
      data_reg   <= data_next;
      status_reg <= status_next;
    end
  end

  assign GET_CNF    = cnf_reg;
  assign GET_DATA   = data_reg;
  assign GET_STATUS = status_reg;
  assign EMA_AVG    = ema_reg;
endmodule // psab_stats_bank

// ===== tb/psab_stats_sva.sv
`timescale 1ns/100ps
`include "psab_defines.svh"
module psab_stats_sva (
  input wire logic                   CLK,              // clock
  input wire logic                   ARST_N,           // async reset
  input wire logic                   GET_REQ,          // request
  input wire psab_pkg::psab_id_t     GET_ID,           // identifier
  input wire logic                   GET_CNF,          // answer strobe
  input wire psab_pkg::psab_data_t   GET_DATA,         // answer value
  input wire psab_pkg::psab_status_e GET_STATUS,       // answer status
  input wire logic                   EMA_SAMPLE_VALID, // ema sample strobe
  input wire logic [15:0]            EMA_SAMPLE,       // ema sample
  input wire logic [15:0]            EMA_AVG           // smoothed value
);
  import psab_pkg::*;
  logic known;
  logic narrow;
  // defined identifiers; all but the frame total are 16 bits or less
  assign known = GET_ID inside {`PSAB_ID_CRC_ERR, `PSAB_ID_BAD_PROTO, `PSAB_ID_TX_DROP,
    `PSAB_ID_RX_DROP, `PSAB_ID_GOOD_FRAME, `PSAB_ID_EVM_AVG, `PSAB_ID_EMA_SHIFT};
  assign narrow = known && (GET_ID != `PSAB_ID_GOOD_FRAME);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // the cycle after a taken request shows the answer, so it is not a take
  sequence s_take;
    GET_REQ && !GET_CNF;
  endsequence
  AST_CNF_LAT: assert property (s_take |=> GET_CNF)
    else $error("no answer one cycle after request");
  AST_CNF_CAUSE: assert property (GET_CNF |-> $past(GET_REQ && !GET_CNF))
    else $error("answer without a taken request");
  AST_VENDOR: assert property (s_take ##0 GET_ID[15] |=> GET_STATUS == PSAB_ANS_VENDOR)
    else $error("vendor identifier not answered as vendor");
  AST_RESERVED: assert property (s_take ##0 (!GET_ID[15] && !known)
    |=> GET_STATUS == PSAB_ANS_RESERVED)
    else $error("undefined standard identifier not answered reserved");
  AST_KNOWN_OK: assert property (s_take ##0 known |=> GET_STATUS == PSAB_ANS_OK)
    else $error("defined identifier not answered ok");
  AST_HOLD: assert property (!GET_CNF |-> $stable(GET_DATA) && $stable(GET_STATUS))
    else $error("answer changed without a new answer");
  AST_ZERO_EXT: assert property (s_take ##0 narrow |=> GET_DATA[31:16] == 16'h0000)
    else $error("narrow attribute not zero extended");
  AST_EMA_FIXED: assert property (EMA_SAMPLE_VALID && EMA_SAMPLE == EMA_AVG
    |=> $stable(EMA_AVG))
    else $error("average moved on a sample equal to it");
endmodule // psab_stats_sva
bind psab_stats_bank psab_stats_sva u_sva (.CLK, .ARST_N, .GET_REQ, .GET_ID, .GET_CNF,
  .GET_DATA, .GET_STATUS, .EMA_SAMPLE_VALID, .EMA_SAMPLE, .EMA_AVG);

// ===== tb/psab_mac_model.sv
`timescale 1ns/100ps
module psab_mac_model (
  input wire logic            CLK,     // clock
  output logic                GET_REQ, // request strobe
  output psab_pkg::psab_id_t  GET_ID   // identifier
);
  import psab_pkg::*;
  // idle at time zero
  initial begin
    GET_REQ = 1'b0;
    GET_ID = 16'hffff;
  end
  // one-cycle request, then a gap so requests are never back to back
  task automatic get(input psab_id_t id);
    @(posedge CLK);
    GET_REQ <= 1'b1;
    GET_ID <= id;
    @(posedge CLK);
    GET_REQ <= 1'b0;
    GET_ID <= ~id; // released id does not keep its value
    @(posedge CLK);
  endtask
endmodule // psab_mac_model

// ===== tb/tb_psab_stats_bank.sv
`timescale 1ns/100ps
`include "psab_defines.svh"
module tb_psab_stats_bank;
  import psab_pkg::*;
  logic clk, arst_n, get_req, get_cnf, snr_valid, ema_load, ema_sv;
  logic crc, proto, tx_req, tx_full, rx_new, rx_full, frame_ok;
  logic [2:0] snr_db;
  logic [6:0] r;
  logic [7:0] ema_value;
  logic [15:0] ema_sample, ema_avg, avg, evm, s;
  logic signed [16:0] d;
  psab_id_t get_id;
  psab_data_t get_data;
  psab_status_e get_status;
  logic [34:0] exp_q[$];
  logic [31:0] cnt [5];
  logic [7:0] lin [8] = '{8'h08, 8'h0b, 8'h10, 8'h17, 8'h20, 8'h2d, 8'h40, 8'h5b};
  psab_id_t ids [7] = '{16'h00a0, 16'h00a1, 16'h00a2, 16'h00a3, 16'h00a4, 16'h00a5, 16'h00a8};
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  psab_mac_model u_mac (.CLK(clk), .GET_REQ(get_req), .GET_ID(get_id));
  psab_stats_bank u_dut (.CLK(clk), .ARST_N(arst_n), .GET_REQ(get_req), .GET_ID(get_id),
    .GET_CNF(get_cnf), .GET_DATA(get_data), .GET_STATUS(get_status), .CRC_FAIL(crc),
    .PROTO_BAD(proto), .TX_REQ(tx_req), .TX_FULL(tx_full), .RX_NEW(rx_new),
    .RX_FULL(rx_full), .FRAME_OK(frame_ok), .SNR_VALID(snr_valid), .SNR_DB(snr_db),
    .EMA_LOAD(ema_load), .EMA_VALUE(ema_value), .EMA_SAMPLE_VALID(ema_sv),
    .EMA_SAMPLE(ema_sample), .EMA_AVG(ema_avg));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (e !== v) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, v);
      n_fail++;
    end
  endtask
  // note the expected answer, then let the partner issue the request
  task automatic get(input psab_id_t id, input psab_status_e st, input logic [31:0] v);
    exp_q.push_back({st == PSAB_ANS_OK, st, v});
    u_mac.get(id);
  endtask
  // answer watcher; data of refused identifiers is left unchecked
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      report_and_stop();
    end
    if (get_cnf === 1'b1) begin
      if (exp_q.size() == 0) chk("answer count", 32'h0, 32'h1);
      else begin
        chk("status", exp_q[0][33:32], get_status);
        if (exp_q[0][34]) chk("data", exp_q[0][31:0], get_data);
        void'(exp_q.pop_front());
      end
    end
  end
  // main sequence
  initial begin
    {arst_n, crc, proto, tx_req, tx_full, rx_new, rx_full, frame_ok} = '0;
    {snr_valid, snr_db, ema_load, ema_value, ema_sv, ema_sample} = '0;
    void'($urandom(71869));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ids[i]) get(ids[i], PSAB_ANS_OK, 32'h0);
    $display("test reset values done");
    @(posedge clk) crc <= 1'b1;
    repeat (65537) @(posedge clk);
    crc <= 1'b0;
    cnt = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    get(ids[0], PSAB_ANS_OK, 32'h1);
    $display("test wrap done");
    repeat (60) begin
      @(posedge clk);
      r = 7'($urandom);
      {crc, proto, tx_req, tx_full, rx_new, rx_full, frame_ok} <= r;
      cnt[0] += r[6];
      cnt[1] += r[5];
      cnt[2] += r[4] & r[3];
      cnt[3] += r[2] & r[1];
      cnt[4] += r[0];
    end
    @(posedge clk) {crc, proto, tx_req, tx_full, rx_new, rx_full, frame_ok} <= '0;
    for (int i = 0; i < 5; i++) get(ids[i], PSAB_ANS_OK, cnt[i]);
    get(16'h0050, PSAB_ANS_RESERVED, 32'h0);
    get(16'h7fff, PSAB_ANS_RESERVED, 32'h0);
    get(16'h8000, PSAB_ANS_VENDOR, 32'h0);
    get(16'hffff, PSAB_ANS_VENDOR, 32'h0);
    $display("test counters and identifiers done");
    evm = '0;
    repeat (16) begin
      @(posedge clk) snr_valid <= 1'b1;
      r = 7'($urandom);
      snr_db <= r[2:0];
      evm += lin[r[2:0]];
    end
    @(posedge clk) snr_valid <= 1'b0;
    get(ids[5], PSAB_ANS_OK, {16'h0, evm});
    @(posedge clk) {ema_load, ema_value} <= {1'b1, 8'h02};
    @(posedge clk) ema_load <= 1'b0;
    get(ids[6], PSAB_ANS_OK, 32'h2);
    avg = '0;
    for (int i = 0; i < 7; i++) begin
      s = (i == 6) ? avg : 16'($urandom) & 16'h3fff;
      @(posedge clk) {ema_sv, ema_sample} <= {1'b1, s};
      d = {1'b0, s} - {1'b0, avg};
      avg = avg + 16'(d >>> 2);
      @(posedge clk) ema_sv <= 1'b0;
      @(negedge clk) chk("ema average", {16'h0, avg}, {16'h0, ema_avg});
    end
    $display("test evm and ema done");
    repeat (3) @(posedge clk);
    chk("pending answers", 32'h0, 32'(exp_q.size()));
    report_and_stop();
  end
endmodule // tb_psab_stats_bank
